/* rtl/floppy_command_host.sv */
// host-side sequencer driving the floppy controller command byte port
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module floppy_command_host (
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    input  wire floppy_host_pkg::sw_req_s sw_req,
    output logic [7:0]                    sw_rdata_q,
    output logic                          irq_q,
    output var floppy_host_pkg::dev_out_s dev_out_q,
    input  wire floppy_host_pkg::dev_in_s dev_in
);
    import floppy_host_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_POLL_W, S_GAP_W, S_POLL_R, S_CAP, S_GAP_R
    } state_e;

    state_e      state_q;
    cmd_kind_e   kind_q;
    logic        flag_q;
    logic [2:0]  sel_q;
    logic [7:0]  par0_q;
    logic [7:0]  par1_q;
    logic [2:0]  idx_q;
    logic [4:0]  nres_q;
    logic [1:0]  cnt_q;
    logic [7:0]  res_q [RES_DEPTH];
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_en_q;
    logic        start;
    logic        issue_wr;
    logic        issue_rd;
    logic        done_ev;
    logic        ovf_ev;
    logic        cap;
    logic [1:0]  clr_bits;
    logic [7:0]  sel_byte;

    function automatic logic [2:0] n_writes(input cmd_kind_e k);
        unique case (k)
            K_SENSE_INT, K_LOCK, K_DUMP, K_RAW: n_writes = 3'd1;
            K_RECAL, K_PERP, K_SENSE_DRV:       n_writes = 3'd2;
            K_CONFIGURE:                        n_writes = 3'd4;
            K_SPECIFY, K_SEEK, K_REL_SEEK:      n_writes = 3'd3;
            default:                            n_writes = 3'd1;
        endcase
    endfunction : n_writes

    function automatic logic [7:0] code_byte(input cmd_kind_e k,
                                             input logic f,
                                             input logic [7:0] raw);
        unique case (k)
            K_RECAL:     code_byte = CODE_RECAL;
            K_SENSE_INT: code_byte = CODE_SENSE_INT;
            K_SPECIFY:   code_byte = CODE_SPECIFY;
            K_SEEK:      code_byte = CODE_SEEK;
            K_CONFIGURE: code_byte = CODE_CONFIGURE;
            K_REL_SEEK:  code_byte = CODE_REL_SEEK | {1'b0, f, 6'h00};
            K_PERP:      code_byte = CODE_PERP;
            K_LOCK:      code_byte = CODE_LOCK | {f, 7'h00};
            K_DUMP:      code_byte = CODE_DUMP;
            K_SENSE_DRV: code_byte = CODE_SENSE_DRV;
            default:     code_byte = raw;
        endcase
    endfunction : code_byte

    assign sel_byte = {5'h00, sel_q[HEAD_BIT], sel_q[1:0]};

    function automatic logic [7:0] byte_at(input logic [2:0] i);
        logic [7:0] b;
        b = 8'h00;
        if (i == 3'd0) begin
            b = code_byte(kind_q, flag_q, par0_q);
        end else begin
            unique case (kind_q)
                // drive only, head bit stays zero
                K_RECAL:     b = {6'h00, sel_q[1:0]};
                // timing bytes, non-DMA flag in par1 bit 0
                K_SPECIFY:   b = (i == 3'd1) ? par0_q : par1_q;
                // target or step count after select
                K_SEEK, K_REL_SEEK: b = (i == 3'd1) ? sel_byte : par1_q;
                K_CONFIGURE: b = (i == 3'd1) ? sel_byte :
                                 (i == 3'd2) ? par0_q : par1_q;
                K_PERP:      b = par0_q;
                K_SENSE_DRV: b = sel_byte;
                default:     b = 8'h00;
            endcase
        end
        byte_at = b;
    endfunction : byte_at

    // orders given while busy are dropped; no queue behind the sequencer
    assign start    = sw_req.wr && sw_req.addr == A_CTRL && state_q == S_IDLE;
    // one byte only when the device asks for it
    assign issue_wr = state_q == S_POLL_W && dev_in.ready && !dev_in.to_host;
    assign issue_rd = state_q == S_POLL_R && dev_in.ready && dev_in.to_host;
    // ready without result ends the command
    assign done_ev  = state_q == S_POLL_R && dev_in.ready && !dev_in.to_host;
    // result byte only stands the cycle after the strobe, first gap cycle
    assign cap      = state_q == S_GAP_R && cnt_q == SETTLE_CYC;
    assign ovf_ev   = cap && nres_q >= 5'(RES_DEPTH);
    assign clr_bits = (sw_req.wr && sw_req.addr == A_IRQ_CLR) ?
                      sw_req.wdata[1:0] : 2'b00;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= S_IDLE;
            idx_q   <= 3'd0;
            cnt_q   <= 2'd0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (start) begin
                        idx_q   <= 3'd0;
                        state_q <= S_POLL_W;
                    end
                end
                S_POLL_W: begin
                    if (issue_wr) begin
                        idx_q   <= idx_q + 3'd1;
                        cnt_q   <= SETTLE_CYC;
                        state_q <= S_GAP_W;
                    end
                end
                // status needs time to follow a strobe before it is trusted
                S_GAP_W: begin
                    if (cnt_q <= 2'd1) begin
                        state_q <= (idx_q == n_writes(kind_q)) ?
                                   S_POLL_R : S_POLL_W;
                    end else begin
                        cnt_q <= cnt_q - 2'd1;
                    end
                end
                S_POLL_R: begin
                    if (issue_rd) begin
                        state_q <= S_CAP;
                    end else if (done_ev) begin
                        state_q <= S_IDLE;
                    end
                end
                S_CAP: begin
                    cnt_q   <= SETTLE_CYC;
                    state_q <= S_GAP_R;
                end
                S_GAP_R: begin
                    if (cnt_q <= 2'd1) begin
                        state_q <= S_POLL_R;
                    end else begin
                        cnt_q <= cnt_q - 2'd1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dev_out_q <= '0;
        end else begin
            dev_out_q.wr <= issue_wr;
            dev_out_q.rd <= issue_rd;
            if (issue_wr) begin
                dev_out_q.wdata <= byte_at(idx_q);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nres_q <= 5'd0;
            for (int i = 0; i < RES_DEPTH; i++) begin
                res_q[i] <= 8'h00;
            end
        end else if (start) begin
            nres_q <= 5'd0;
        end else if (cap) begin
            // read data stand in the cycle after the read strobe
            if (!ovf_ev) begin
                res_q[nres_q[1:0]] <= dev_in.rdata;
            end
            if (nres_q != 5'h1F) begin
                nres_q <= nres_q + 5'd1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            kind_q <= K_RECAL;
            flag_q <= 1'b0;
            sel_q  <= 3'd0;
            par0_q <= 8'h00;
            par1_q <= 8'h00;
        end else if (sw_req.wr && state_q == S_IDLE) begin
            unique case (sw_req.addr)
                A_CTRL: begin
                    kind_q <= (sw_req.wdata[3:0] > 4'(K_RAW)) ? K_RAW :
                              cmd_kind_e'(sw_req.wdata[3:0]);
                    flag_q <= sw_req.wdata[CTRL_FLAG_BIT];
                end
                A_SEL:   sel_q  <= sw_req.wdata[2:0];
                A_PAR0:  par0_q <= sw_req.wdata;
                A_PAR1:  par1_q <= sw_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_stat_q <= 2'b00;
            irq_en_q   <= 2'b00;
            irq_q      <= 1'b0;
        end else begin
            // a new event outranks a clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~clr_bits) | {ovf_ev, done_ev};
            if (sw_req.wr && sw_req.addr == A_IRQ_EN) begin
                irq_en_q <= sw_req.wdata[1:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sw_rdata_q <= 8'h00;
        end else if (sw_req.rd) begin
            unique case (sw_req.addr)
                A_CTRL:     sw_rdata_q <= {3'b000, flag_q, kind_q};
                A_SEL:      sw_rdata_q <= {5'h00, sel_q};
                A_PAR0:     sw_rdata_q <= par0_q;
                A_PAR1:     sw_rdata_q <= par1_q;
                A_STAT:     sw_rdata_q <= {state_q != S_IDLE, 2'b00, nres_q};
                A_IRQ_STAT: sw_rdata_q <= {6'h00, irq_stat_q};
                A_IRQ_EN:   sw_rdata_q <= {6'h00, irq_en_q};
                A_RES0, 4'h9, 4'hA, 4'hB:
                            sw_rdata_q <= res_q[sw_req.addr[1:0]];
                default:    sw_rdata_q <= 8'h00;
            endcase
        end else begin
            sw_rdata_q <= 8'h00;
        end
    end

    AST_STROBE_EXCL: assert property (@(posedge ref_clk) disable iff (srst)
        !(dev_out_q.wr && dev_out_q.rd)) else $error("write and read strobe together");
    AST_WR_SPACING: assert property (@(posedge ref_clk) disable iff (srst)
        dev_out_q.wr |=> !dev_out_q.wr [*2]) else $error("write strobes too close");
    AST_RECAL_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd0 && kind_q == K_RECAL
        |=> dev_out_q.wdata == CODE_RECAL) else $error("bad recalibrate code");
    AST_SENSE_INT: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_SENSE_INT
        |=> dev_out_q.wdata == CODE_SENSE_INT ##2 state_q == S_POLL_R)
        else $error("sense interrupt not one byte");
    AST_SPECIFY_ND: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_SPECIFY && idx_q == 3'd2
        |=> dev_out_q.wdata[0] == $past(par1_q[0])) else $error("non-DMA flag lost");
    AST_SEEK_TGT: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_SEEK && idx_q == 3'd2
        |=> dev_out_q.wdata == $past(par1_q)) else $error("seek target wrong");
    AST_REL_DIR: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_REL_SEEK && idx_q == 3'd0
        |=> dev_out_q.wdata[7] && dev_out_q.wdata[3:0] == 4'hF
            && dev_out_q.wdata[DIR_BIT] == $past(flag_q))
        else $error("relative seek code wrong");
    AST_LOCK_BITS: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_LOCK
        |=> dev_out_q.wdata[6:0] == CODE_LOCK[6:0]
            && dev_out_q.wdata[LOCK_BIT] == $past(flag_q))
        else $error("lock code wrong");
    AST_SEL_ZERO: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd1 && (kind_q == K_SEEK || kind_q == K_SENSE_DRV
            || kind_q == K_CONFIGURE || kind_q == K_REL_SEEK || kind_q == K_RECAL)
        |=> dev_out_q.wdata[7:3] == 5'h00) else $error("select byte high bits set");
    AST_RD_SPACING: assert property (@(posedge ref_clk) disable iff (srst)
        dev_out_q.rd |=> !dev_out_q.rd [*2]) else $error("read strobes too close");
    AST_WR_READY: assert property (@(posedge ref_clk) disable iff (srst)
        dev_out_q.wr |-> $past(dev_in.ready && !dev_in.to_host))
        else $error("write strobe without request");
    AST_RD_READY: assert property (@(posedge ref_clk) disable iff (srst)
        dev_out_q.rd |-> $past(dev_in.ready && dev_in.to_host))
        else $error("read strobe without result");
    AST_START_BUSY: assert property (@(posedge ref_clk) disable iff (srst)
        start |=> state_q == S_POLL_W) else $error("command did not start");
    AST_DONE_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
        done_ev |=> state_q == S_IDLE) else $error("command did not end");
    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (srst)
        irq_q == $past(|(irq_stat_q & irq_en_q))) else $error("irq level wrong");
    AST_RES_COUNT: assert property (@(posedge ref_clk) disable iff (srst)
        cap && nres_q != 5'h1F |=> nres_q == $past(nres_q) + 5'd1)
        else $error("result count wrong");
    AST_OVF_KEEP: assert property (@(posedge ref_clk) disable iff (srst)
        ovf_ev |=> res_q[0] == $past(res_q[0])) else $error("overflow overwrote");
    AST_SPEC_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd0 && kind_q == K_SPECIFY
        |=> dev_out_q.wdata == CODE_SPECIFY) else $error("bad specify code");
    AST_CONF_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd0 && kind_q == K_CONFIGURE
        |=> dev_out_q.wdata == CODE_CONFIGURE) else $error("bad configure code");
    AST_PERP_PAR: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd1 && kind_q == K_PERP
        |=> dev_out_q.wdata == $past(par0_q)) else $error("perp byte wrong");
    AST_DUMP_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_DUMP
        |=> dev_out_q.wdata == CODE_DUMP) else $error("bad dump code");
    AST_SDRV_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && idx_q == 3'd0 && kind_q == K_SENSE_DRV
        |=> dev_out_q.wdata == CODE_SENSE_DRV) else $error("bad sense drive code");
    AST_RAW_CODE: assert property (@(posedge ref_clk) disable iff (srst)
        issue_wr && kind_q == K_RAW
        |=> dev_out_q.wdata == $past(par0_q)) else $error("raw code wrong");
endmodule : floppy_command_host
`default_nettype wire

/* rtl/floppy_host_pkg.sv */
// constants and types for the floppy command host
package floppy_host_pkg;
    localparam logic [3:0] A_CTRL     = 4'h0;
    localparam logic [3:0] A_SEL      = 4'h1;
    localparam logic [3:0] A_PAR0     = 4'h2;
    localparam logic [3:0] A_PAR1     = 4'h3;
    localparam logic [3:0] A_STAT     = 4'h4;
    localparam logic [3:0] A_IRQ_STAT = 4'h5;
    localparam logic [3:0] A_IRQ_CLR  = 4'h6;
    localparam logic [3:0] A_IRQ_EN   = 4'h7;
    localparam logic [3:0] A_RES0     = 4'h8;
    localparam int         RES_DEPTH  = 4;
    localparam int         CTRL_FLAG_BIT = 4;
    localparam int         STAT_BUSY_BIT = 7;
    localparam int         EV_DONE    = 0;
    localparam int         EV_OVF     = 1;
    localparam int         HEAD_BIT   = 2;
    localparam int         DIR_BIT    = 6;
    localparam int         LOCK_BIT   = 7;
    localparam logic [7:0] CODE_RECAL      = 8'h07;
    localparam logic [7:0] CODE_SENSE_INT  = 8'h08;
    localparam logic [7:0] CODE_SPECIFY    = 8'h03;
    localparam logic [7:0] CODE_SEEK       = 8'h0F;
    localparam logic [7:0] CODE_CONFIGURE  = 8'h13;
    localparam logic [7:0] CODE_REL_SEEK   = 8'h8F;
    localparam logic [7:0] CODE_PERP       = 8'h12;
    localparam logic [7:0] CODE_LOCK       = 8'h14;
    localparam logic [7:0] CODE_DUMP       = 8'h0E;
    localparam logic [7:0] CODE_SENSE_DRV  = 8'h04;
    localparam int         CLK_NS     = 40;
    localparam int         SETTLE_NS  = 80;
    localparam logic [1:0] SETTLE_CYC =
        2'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [3:0] {
        K_RECAL, K_SENSE_INT, K_SPECIFY, K_SEEK, K_CONFIGURE, K_REL_SEEK,
        K_PERP, K_LOCK, K_DUMP, K_SENSE_DRV, K_RAW
    } cmd_kind_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } sw_req_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dev_out_s;

    typedef struct packed {
        logic       ready;
        logic       to_host;
        logic [7:0] rdata;
    } dev_in_s;
endpackage : floppy_host_pkg

/* tb/floppy_drive_model.sv */
// behavioural floppy controller that answers the host byte port
`timescale 1ns/1ns
`default_nettype none
module floppy_drive_model (
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic                      slow,
    input  wire floppy_host_pkg::dev_out_s host_out,
    output var  floppy_host_pkg::dev_in_s  dev_in
);
    import floppy_host_pkg::*;
    logic [7:0] present_cylinder [4];
    logic [7:0] cmd [4];
    logic [7:0] spec [2];
    logic [7:0] st0_q;
    logic [7:0] rdata_q;
    logic [3:0] busy_q;
    logic       to_host_q;
    int         idx;
    logic [7:0] rx_log [$];
    logic [7:0] res [$];

    assign dev_in = '{ready: busy_q == 4'h0, to_host: to_host_q,
                      rdata: rdata_q};

    function automatic int cmd_len(input logic [7:0] c);
        if ((c & 8'hBF) == CODE_REL_SEEK) return 3;
        if ((c & 8'h7F) == CODE_LOCK) return 1;
        case (c)
            CODE_RECAL, CODE_PERP, CODE_SENSE_DRV: return 2;
            CODE_SPECIFY, CODE_SEEK: return 3;
            CODE_CONFIGURE: return 4;
            default: return 1;
        endcase
    endfunction : cmd_len

    task automatic execute();
        logic [1:0] d;
        d = cmd[1][1:0];
        res.delete();
        if ((cmd[0] & 8'h7F) == CODE_LOCK) res.push_back({3'h0, cmd[0][7], 4'h0});
        else if ((cmd[0] & 8'hBF) == CODE_REL_SEEK) begin
            present_cylinder[d] = cmd[0][6] ? present_cylinder[d] + cmd[2] : present_cylinder[d] - cmd[2];
            st0_q = 8'h20 | cmd[1];
        end else case (cmd[0])
            CODE_RECAL: present_cylinder[d] = 8'h00;
            CODE_SEEK: present_cylinder[d] = cmd[2];
            CODE_SENSE_INT: res = '{st0_q, present_cylinder[st0_q[1:0]]};
            CODE_SPECIFY: spec = '{cmd[1], cmd[2]};
            CODE_DUMP: res = '{present_cylinder[0], present_cylinder[1], present_cylinder[2], present_cylinder[3], spec[0], spec[1]};
            CODE_SENSE_DRV: res.push_back(8'h28 | cmd[1]);
            CODE_CONFIGURE, CODE_PERP: ;
            default: res.push_back(8'h80);
        endcase
        if (cmd[0] == CODE_RECAL || cmd[0] == CODE_SEEK) st0_q = 8'h20 | cmd[1];
        if (res.size() == 1 && res[0] == 8'h80) st0_q = 8'h80;
        to_host_q <= res.size() != 0;
        busy_q <= slow ? 4'd9 : 4'd1;
    endtask : execute

    always @(posedge ref_clk) begin
        // released bus inverts every cycle, so data taken one cycle late never matches
        rdata_q <= ~rdata_q;
        if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
        if (srst) begin
            present_cylinder = '{default: 8'h00};
            spec = '{default: 8'h00};
            st0_q = 8'h00;
            idx = 0;
            res.delete();
            to_host_q <= 1'b0;
            busy_q <= 4'h0;
            rdata_q <= 8'h5A;
        end else if (host_out.wr) begin
            rx_log.push_back(host_out.wdata);
            cmd[idx[1:0]] = host_out.wdata;
            busy_q <= slow ? 4'd3 : 4'd0;
            idx = idx + 1;
            if (idx == cmd_len(cmd[0])) begin
                idx = 0;
                execute();
            end
        end else if (host_out.rd) begin
            rdata_q <= res.pop_front();
            to_host_q <= res.size() != 0;
            busy_q <= slow ? 4'd2 : 4'd0;
        end
    end
endmodule : floppy_drive_model
`default_nettype wire

/* tb/floppy_command_sequencer_test.sv */
// self-checking bench for the floppy command host
`timescale 1ns/1ns
`default_nettype none
module floppy_command_sequencer_test;
    import floppy_host_pkg::*;
    logic       ref_clk;
    logic       srst;
    logic       slow;
    logic       irq_q;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [7:0] ien;
    logic [7:0] mst0;
    logic [7:0] mpcn [4];
    logic [7:0] mspec [2];
    sw_req_s    req;
    dev_out_s   dout;
    dev_in_s    din;
    int         failures;
    int         check_count;

    floppy_command_host dut (.ref_clk(ref_clk), .srst(srst), .sw_req(req),
        .sw_rdata_q(rdata), .irq_q(irq_q), .dev_out_q(dout), .dev_in(din));
    floppy_drive_model dev (.ref_clk(ref_clk), .srst(srst), .slow(slow),
        .host_out(dout), .dev_in(din));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic sw_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : sw_wr

    task automatic sw_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        v = rdata;
    endtask : sw_rd

    // expected byte list and results, mirror of drive state updated
    function automatic void expect_cmd(input logic [3:0] k, input logic f,
        input logic [2:0] s, input logic [7:0] p0, input logic [7:0] p1,
        ref logic [7:0] b [$], ref logic [7:0] r [$]);
        logic [7:0] sel;
        sel = {5'h0, s};
        r = {};
        case (k)
            4'd0: b = '{CODE_RECAL, {6'h0, s[1:0]}};
            4'd1: b = '{CODE_SENSE_INT};
            4'd2: b = '{CODE_SPECIFY, p0, p1};
            4'd3: b = '{CODE_SEEK, sel, p1};
            4'd4: b = '{CODE_CONFIGURE, sel, p0, p1};
            4'd5: b = '{CODE_REL_SEEK | {1'b0, f, 6'h0}, sel, p1};
            4'd6: b = '{CODE_PERP, p0};
            4'd7: b = '{CODE_LOCK | {f, 7'h0}};
            4'd8: b = '{CODE_DUMP};
            4'd9: b = '{CODE_SENSE_DRV, sel};
            default: b = '{p0};
        endcase
        if (k == 4'd1) r = '{mst0, mpcn[mst0[1:0]]};
        if (k == 4'd7) r = '{{3'h0, f, 4'h0}};
        if (k == 4'd8) r = '{mpcn[0], mpcn[1], mpcn[2], mpcn[3], mspec[0], mspec[1]};
        if (k == 4'd9) r = '{8'h28 | sel};
        if (k >= 4'd10) r = '{8'h80};
        if (k == 4'd2) mspec = '{p0, p1};
        if (k == 4'd0) mpcn[s[1:0]] = 8'h00;
        if (k == 4'd3) mpcn[s[1:0]] = p1;
        if (k == 4'd5) mpcn[s[1:0]] = f ? mpcn[s[1:0]] + p1 : mpcn[s[1:0]] - p1;
        if (k == 4'd0) mst0 = {6'h8, s[1:0]};
        if (k == 4'd3 || k == 4'd5) mst0 = 8'h20 | sel;
        if (k >= 4'd10) mst0 = 8'h80;
    endfunction : expect_cmd

    task automatic run(input logic [3:0] k, input logic f, input logic [2:0] s,
        input logic [7:0] p0, input logic [7:0] p1, input logic poke);
        logic [7:0] b [$];
        logic [7:0] r [$];
        logic [7:0] v;
        int         n;
        // raw codes are kept clear of every defined code
        if (k >= 4'd10) p0 = 8'hE0 | (p0 & 8'h1F);
        expect_cmd(k, f, s, p0, p1, b, r);
        dev.rx_log.delete();
        sw_wr(A_SEL, {5'h0, s});
        sw_wr(A_PAR0, p0);
        sw_wr(A_PAR1, p1);
        sw_wr(A_CTRL, {3'h0, f, k});
        if (poke) sw_wr(A_CTRL, 8'h17);
        n = 0;
        v = 8'h80;
        while (v[7] !== 1'b0 && n < 400) begin
            sw_rd(A_STAT, v);
            n++;
        end
        check8(8'(dev.rx_log.size()), 8'(b.size()));
        foreach (b[i]) if (i < dev.rx_log.size()) check8(dev.rx_log[i], b[i]);
        check8({v[7], 2'h0, v[4:0]}, 8'(r.size()));
        foreach (r[i]) if (i < RES_DEPTH) begin
            sw_rd(A_RES0 + 4'(i), v);
            check8(v, r[i]);
        end
        sw_rd(A_IRQ_STAT, v);
        check8(v, {6'h0, r.size() > RES_DEPTH, 1'b1});
        check8({7'h0, irq_q}, {7'h0, |(v & ien)});
        sw_wr(A_IRQ_CLR, 8'h03);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check8({7'h0, irq_q}, 8'h00);
    endtask : run

    task automatic conclude();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        slow = 1'b0;
        req = '0;
        ien = 8'h00;
        failures = 0;
        check_count = 0;
        mst0 = 8'h00;
        mpcn = '{default: 8'h00};
        mspec = '{default: 8'h00};
        void'($urandom(15));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            sw_rd(4'(a), rv);
            check8(rv, 8'h00);
        end
        ien = 8'h01;
        sw_wr(A_IRQ_EN, ien);
        for (int p = 0; p < 2; p++) begin
            slow <= p[0];
            for (int k = 0; k < 11; k++) begin
                run(4'(k), p[0], 3'($urandom), 8'($urandom), 8'($urandom), 1'b0);
            end
        end
        ien = 8'h02;
        sw_wr(A_IRQ_EN, ien);
        run(4'd1, 1'b0, 3'd0, 8'h00, 8'h00, 1'b0);
        run(4'd8, 1'b0, 3'd0, 8'h00, 8'h00, 1'b0);
        run(4'd3, 1'b0, 3'($urandom), 8'h00, 8'($urandom), 1'b1);
        repeat (16) begin
            slow <= 1'($urandom);
            run(4'($urandom), 1'($urandom), 3'($urandom), 8'($urandom),
                8'($urandom), 1'b0);
        end
        conclude();
    end
endmodule : floppy_command_sequencer_test
`default_nettype wire
